// ---- design/ext_port_pkg.sv ----
// Shared constants, types and state layout for the external memory port strobes.
// Assumes one core clock at 20 MHz and that all request inputs come from that clock.
`default_nettype none

package ext_port_pkg;

    // ------------------------------------------------------------------
    // Address and bank layout
    // ------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int BANK_W = 2;
    localparam int BANK_COUNT = 4;
    localparam int BANK_LSB = 22;
    localparam logic [BANK_W-1:0] BANK_BOOT = 2'h1;
    localparam logic [BANK_W-1:0] BANK_FLAG2 = 2'h2;
    localparam logic [BANK_W-1:0] BANK_FLAG3 = 2'h3;
    localparam logic [BANK_COUNT-1:0] SELECTS_IDLE = 4'hF;
    localparam logic STROBE_IDLE = 1'b1;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int STROBE_MIN_NS = 100;
    // Least time, so round up to whole cycles
    localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam int STRAP_W = 2;
    // Capture one edge after the strap synchroniser's last stage has filled
    localparam logic [STRAP_W-1:0] STRAP_SETTLE = 2'h3;

    // ------------------------------------------------------------------
    // Modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STROBE = 2'b01,
        ST_SELECT = 2'b10
    } access_state_t;

    typedef enum logic [1:0] {
        F2_GPIO = 2'b00,
        F2_IRQ = 2'b01,
        F2_BANK = 2'b10
    } flag2_mode_t;

    typedef enum logic [1:0] {
        F3_GPIO = 2'b00,
        F3_TIMER = 2'b01,
        F3_BANK = 2'b10
    } flag3_mode_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic cond_true;
        logic boot_fetch;
        logic [ADDR_W-1:0] addr;
    } access_req_t;

    typedef struct packed {
        logic row_n;
        logic col_n;
        logic we_n;
    } sdram_cmd_t;

    localparam sdram_cmd_t SDRAM_CMD_IDLE = 3'h7;

    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;

    localparam pin_drive_t PIN_RELEASED = 2'h0;

    typedef struct packed {
        access_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic [BANK_COUNT-1:0] sel_n;
        logic rd_n;
        logic wr_n;
        logic done;
        logic ready;
        sdram_cmd_t sdram;
        pin_drive_t f2;
        pin_drive_t f3;
        logic [1:0] flag_in;
        logic irq2;
        logic boot;
        logic [STRAP_W-1:0] strap_wait;
    } port_state_t;

endpackage

`default_nettype wire

// ---- design/level_sync.sv ----
// Two-stage synchroniser for one level that arrives from a pin.
// Assumes the destination logic reads only the last stage.
`default_nettype none

module level_sync
    import ext_port_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES,
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (STAGES < 2) begin : g_bad_stages
        $error("level_sync needs at least two stages");
    end

    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;

    // Shift in; first stage feeds only the second
    always_comb begin
        next_chain = {chain[STAGES-2:0], d};
    end

    // Reset to the pin's idle level so nothing glitches at release
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            chain <= {STAGES{RESET_VAL}};
        end else begin
            chain <= next_chain;
        end
    end

    assign q = chain[STAGES-1];

endmodule

`default_nettype wire

// ---- design/external_memory_strobes.sv ----
// External memory port strobes: bank selects, read/write strobes, flag pin roles,
// and the SDRAM row/column command strobes.
// Assumes requests, modes and SDRAM command levels come from core logic on core_clk;
// acknowledge, flag inputs and the boot strap come from pins.
//
// Functional notes
// [RULE_01] Each bank select goes low as chip select for its own bank.
// [RULE_02] Bank selects decode from the address and switch with the address outputs.
// [RULE_03] With no external access in progress every bank select stays high.
// [RULE_04] A conditional access asserts its bank select even when the condition fails.
// [RULE_05] Read strobe goes low for every word read from external memory.
// [RULE_06] Write strobe goes low for every word written to external memory.
// [RULE_07] Bank select 1 serves as boot chip select in external port boot.
// [RULE_08] Flag pin 2 is a general flag, interrupt input 2, or bank select 2.
// [RULE_09] Flag pin 3 is a general flag, timer expired output, or bank select 3.
// [RULE_10] Row strobe drives the SDRAM RAS input as part of the command.
// [RULE_11] Column strobe moves together with the other SDRAM command outputs.
// [RULE_12] A slow device pulls acknowledge low; the access holds until it returns high. Code holds strobed accesses only; ST_SELECT ignores ack.
// [RULE_13] At most one bank select is asserted during any single access.
`default_nettype none

module external_memory_strobes
    import ext_port_pkg::*;
#(
    parameter int STROBE_LEN = STROBE_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire access_req_t req,
    output logic req_ready,
    output logic done,
    input wire sdram_cmd_t sdram_cmd_in,
    input wire flag2_mode_t flag2_mode,
    input wire flag3_mode_t flag3_mode,
    input wire logic [1:0] flag_gp_out,
    input wire logic [1:0] flag_gp_oe,
    input wire logic timer_expired,
    input wire logic flag2_pin_i,
    input wire logic flag3_pin_i,
    output logic flag2_pin_o,
    output logic flag2_pin_oe,
    output logic flag3_pin_o,
    output logic flag3_pin_oe,
    output logic [1:0] flag_in_sync,
    output logic irq2_level,
    input wire logic external_port_boot,
    output logic boot_mode,
    input wire logic ack,
    output logic [ADDR_W-1:0] ext_addr,
    output logic [1:0] bank_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic sdram_we_n
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // Counter loads the larger of STROBE_LEN-1 and SYNC_STAGES, so it must fit CNT_W bits
    if (STROBE_LEN < 1 || STROBE_LEN > (2 ** CNT_W)) begin : g_bad_strobe
        $error("STROBE_LEN out of range for the strobe counter");
    end

    // A low ack taken once the select is down needs SYNC_STAGES edges to show,
    // so the strobe never ends before then, whatever STROBE_LEN asks
    localparam int HOLD_CYCLES = (STROBE_LEN - 1 > SYNC_STAGES) ? STROBE_LEN - 1 : SYNC_STAGES;
    localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(HOLD_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [STRAP_W-1:0] STRAP_ONE = 2'h1;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic ack_sync;
    logic flag2_sync;
    logic flag3_sync;
    logic strap_sync;

    // Acknowledge idles high (pulled up), so reset the chain high
    level_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_ack_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(ack),
        .q(ack_sync)
    );

    level_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_flag2_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(flag2_pin_i),
        .q(flag2_sync)
    );

    level_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_flag3_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(flag3_pin_i),
        .q(flag3_sync)
    );

    level_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_strap_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .d(external_port_boot),
        .q(strap_sync)
    );

    // ------------------------------------------------------------------
    // Bank decode
    // ------------------------------------------------------------------
    port_state_t s;
    port_state_t next_s;
    logic [BANK_W-1:0] bank;
    logic bank_enabled;
    logic [BANK_COUNT-1:0] dec_sel_n;
    logic taken;

    assign taken = req_valid && s.ready;

    // One-hot low select from the bank field; banks 2/3 need their flag pin in bank mode
    always_comb begin
        bank = req.addr[BANK_LSB +: BANK_W]; // [RULE_02]
        if (req.boot_fetch && s.boot) begin
            bank = BANK_BOOT; // [RULE_07]
        end
        unique case (bank)
            BANK_FLAG2: bank_enabled = (flag2_mode == F2_BANK); // [RULE_08]
            BANK_FLAG3: bank_enabled = (flag3_mode == F3_BANK); // [RULE_09]
            default: bank_enabled = 1'b1;
        endcase
        dec_sel_n = SELECTS_IDLE;
        if (bank_enabled) begin
            dec_sel_n[bank] = 1'b0; // [RULE_01] [RULE_13]
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Access sequencer, flag pin roles, SDRAM command register and boot strap
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        unique case (s.st)
            ST_IDLE: begin
                next_s.sel_n = SELECTS_IDLE; // [RULE_03]
                if (taken) begin
                    // Address and select load in one edge so they switch together
                    next_s.addr = req.addr; // [RULE_02]
                    next_s.sel_n = dec_sel_n; // [RULE_01] [RULE_04]
                    next_s.ready = 1'b0;
                    next_s.cnt = STROBE_LOAD;
                    if (req.cond_true) begin
                        next_s.st = ST_STROBE;
                        next_s.rd_n = req.write; // [RULE_05]
                        next_s.wr_n = !req.write; // [RULE_06]
                    end else begin
                        // Failed condition: select still shows, no strobe
                        next_s.st = ST_SELECT; // [RULE_04]
                    end
                end
            end
            ST_STROBE: begin
                if (s.cnt != CNT_ZERO) begin
                    next_s.cnt = s.cnt - CNT_ONE;
                end else if (ack_sync) begin
                    // Wait states only start once the least strobe time is met
                    next_s.st = ST_IDLE; // [RULE_12]
                    next_s.sel_n = SELECTS_IDLE; // [RULE_03]
                    next_s.rd_n = STROBE_IDLE;
                    next_s.wr_n = STROBE_IDLE;
                    next_s.done = 1'b1;
                    next_s.ready = 1'b1;
                end
            end
            ST_SELECT: begin
                next_s.st = ST_IDLE;
                next_s.sel_n = SELECTS_IDLE; // [RULE_03]
                next_s.done = 1'b1;
                next_s.ready = 1'b1;
            end
            default: begin
                // Illegal code: return to a quiet bus
                next_s.st = ST_IDLE;
                next_s.sel_n = SELECTS_IDLE;
                next_s.rd_n = STROBE_IDLE;
                next_s.wr_n = STROBE_IDLE;
                next_s.ready = 1'b1;
            end
        endcase

        // SDRAM command lines register as one word so they never skew
        next_s.sdram = sdram_cmd_in; // [RULE_10] [RULE_11]

        // Flag pin 2 role
        unique case (flag2_mode)
            F2_IRQ: next_s.f2 = PIN_RELEASED; // [RULE_08]
            F2_BANK: next_s.f2 = '{o: next_s.sel_n[2], oe: 1'b1}; // [RULE_08]
            default: next_s.f2 = '{o: flag_gp_out[0], oe: flag_gp_oe[0]};
        endcase

        // Flag pin 3 role
        unique case (flag3_mode)
            F3_TIMER: next_s.f3 = '{o: timer_expired, oe: 1'b1}; // [RULE_09]
            F3_BANK: next_s.f3 = '{o: next_s.sel_n[3], oe: 1'b1}; // [RULE_09]
            default: next_s.f3 = '{o: flag_gp_out[1], oe: flag_gp_oe[1]};
        endcase

        next_s.flag_in = {flag3_sync, flag2_sync};
        next_s.irq2 = (flag2_mode == F2_IRQ) && flag2_sync; // [RULE_08]

        // Strap is sampled once, after the synchroniser has filled
        if (s.strap_wait != STRAP_SETTLE) begin
            next_s.strap_wait = s.strap_wait + STRAP_ONE;
            if (s.strap_wait + STRAP_ONE == STRAP_SETTLE) begin
                next_s.boot = strap_sync; // [RULE_07]
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset leaves every strobe high and both flag pins as inputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s.st <= ST_IDLE;
            s.cnt <= CNT_ZERO;
            s.addr <= '0;
            s.sel_n <= SELECTS_IDLE;
            s.rd_n <= STROBE_IDLE;
            s.wr_n <= STROBE_IDLE;
            s.done <= 1'b0;
            s.ready <= 1'b1;
            s.sdram <= SDRAM_CMD_IDLE;
            s.f2 <= PIN_RELEASED;
            s.f3 <= PIN_RELEASED;
            s.flag_in <= 2'h0;
            s.irq2 <= 1'b0;
            s.boot <= 1'b0;
            s.strap_wait <= 2'h0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign req_ready = s.ready;
    assign done = s.done;
    assign ext_addr = s.addr;
    assign bank_select_n = s.sel_n[1:0];
    assign read_strobe_n = s.rd_n;
    assign write_strobe_n = s.wr_n;
    assign row_strobe_n = s.sdram.row_n;
    assign column_strobe_n = s.sdram.col_n;
    assign sdram_we_n = s.sdram.we_n;
    assign flag2_pin_o = s.f2.o;
    assign flag2_pin_oe = s.f2.oe;
    assign flag3_pin_o = s.f3.o;
    assign flag3_pin_oe = s.f3.oe;
    assign flag_in_sync = s.flag_in;
    assign irq2_level = s.irq2;
    assign boot_mode = s.boot;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic plain_bank0;
    assign plain_bank0 = (req.addr[BANK_LSB +: BANK_W] == 2'h0) && !req.boot_fetch;

    AST_BANK0_SELECT: assert property ( // [RULE_01]
        taken && plain_bank0 |=> !bank_select_n[0] && bank_select_n[1])
        else $error("bank 0 access did not drive select 0 low alone");

    AST_ADDR_SEL_TOGETHER: assert property ( // [RULE_02]
        taken |=> ext_addr == $past(req.addr) && s.sel_n == $past(dec_sel_n))
        else $error("address and bank select did not switch together");

    AST_IDLE_SELECTS_HIGH: assert property ( // [RULE_03]
        req_ready |-> s.sel_n == SELECTS_IDLE && read_strobe_n && write_strobe_n)
        else $error("bank select active with no access in progress");

    AST_COND_FALSE_SELECT: assert property ( // [RULE_04]
        taken && !req.cond_true && dec_sel_n != SELECTS_IDLE
            |=> s.sel_n != SELECTS_IDLE && read_strobe_n && write_strobe_n ##1 done)
        else $error("failed-condition access lost its bank select");

    AST_READ_STROBE: assert property ( // [RULE_05]
        taken && req.cond_true && !req.write |=> !read_strobe_n && write_strobe_n)
        else $error("read access without read strobe");

    AST_WRITE_STROBE: assert property ( // [RULE_06]
        taken && req.cond_true && req.write |=> !write_strobe_n && read_strobe_n)
        else $error("write access without write strobe");

    AST_STROBE_MIN_LEN: assert property ( // [RULE_05]
        $rose(read_strobe_n) || $rose(write_strobe_n)
            |-> !$past(read_strobe_n, STROBE_LEN) || !$past(write_strobe_n, STROBE_LEN))
        else $error("strobe shorter than its least length");

    AST_BOOT_SELECT: assert property ( // [RULE_07]
        taken && req.boot_fetch && boot_mode |=> !bank_select_n[1] && bank_select_n[0])
        else $error("boot fetch did not use bank select 1");

    AST_FLAG2_IRQ_INPUT: assert property ( // [RULE_08]
        flag2_mode == F2_IRQ ##1 flag2_mode == F2_IRQ |-> !flag2_pin_oe)
        else $error("flag pin 2 driven while an interrupt input");

    AST_FLAG3_TIMER: assert property ( // [RULE_09]
        flag3_mode == F3_TIMER |=> flag3_pin_oe && flag3_pin_o == $past(timer_expired))
        else $error("flag pin 3 does not show timer expired");

    AST_ROW_STROBE: assert property ( // [RULE_10]
        $changed(sdram_cmd_in.row_n) |=> row_strobe_n == $past(sdram_cmd_in.row_n))
        else $error("row strobe does not follow the command");

    AST_SDRAM_TOGETHER: assert property ( // [RULE_11]
        1'b1 |=> {row_strobe_n, column_strobe_n, sdram_we_n} == $past(sdram_cmd_in))
        else $error("SDRAM command strobes not moved together");

    AST_ACK_HOLDS: assert property ( // [RULE_12]
        s.st == ST_STROBE && s.cnt == CNT_ZERO && !ack_sync
            |=> s.st == ST_STROBE && (!read_strobe_n || !write_strobe_n))
        else $error("access ended while acknowledge was low");

    AST_ONE_SELECT: assert property ( // [RULE_13]
        $onehot0(~s.sel_n) && !(!read_strobe_n && !write_strobe_n))
        else $error("more than one bank select or both strobes low");

    COV_READ_DONE: cover property (
        taken && req.cond_true && !req.write ##[1:20] done);
    COV_WAIT_STATE: cover property (
        s.st == ST_STROBE && s.cnt == CNT_ZERO && !ack_sync ##[1:20] done);
    COV_COND_FALSE: cover property (
        taken && !req.cond_true ##2 done);
    COV_BOOT_FETCH: cover property (
        taken && req.boot_fetch && boot_mode);

endmodule

`default_nettype wire

// ---- tb/ext_mem_model.sv ----
// Far-side model: one shared memory device behind all four selects that may stretch an access.
// Assumes selects come from the strobe block on the same core clock.
`default_nettype none

module ext_mem_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] sel_n,
    input wire logic [3:0] wait_cycles,
    output logic ack
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] held;

    // Cycles since a select fell; cleared once every select is high again
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            held <= 4'h0;
        end else if (&sel_n) begin
            held <= 4'h0;
        end else if (held != 4'hF) begin
            held <= held + 4'h1;
        end
    end

    // Low while the wait runs, otherwise the pull-up wins
    assign ack = (!(&sel_n) && (held < wait_cycles)) ? 1'h0 : 1'h1;
endmodule

`default_nettype wire

// ---- tb/tb_external_memory_strobes.sv ----
// Self-checking bench for the external memory port strobes.
// Assumes the shared package is compiled first and the far-side model beside it.
`default_nettype none

module tb_external_memory_strobes;
    import ext_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SLEN = 2;
    localparam int LIMIT = 3000;

    typedef struct packed {
        logic [3:0] sel;
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
    } seen_t;

    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic req_valid = 1'h0;
    access_req_t req = '0;
    sdram_cmd_t sd_in = SDRAM_CMD_IDLE;
    flag2_mode_t f2m = F2_BANK;
    flag3_mode_t f3m = F3_BANK;
    logic [1:0] gp_out = 2'h0;
    logic [1:0] gp_oe = 2'h0;
    logic tmr = 1'h0;
    logic f2_drv = 1'h1;
    logic f3_drv = 1'h1;
    logic strap = 1'h1;
    logic [3:0] wait_c = 4'h0;
    logic req_ready, done, f2_o, f2_oe, f3_o, f3_oe, irq2, boot_mode, ack;
    logic rd_n, wr_n, ras_n, cas_n, we_n, f2_wire, f3_wire;
    logic [1:0] fsync, bsel_n;
    logic [ADDR_W-1:0] ext_addr;
    logic [3:0] sel4;
    seen_t exp_q[$];
    int lmin_q[$];
    int lmax_q[$];
    seen_t acc;
    logic busy = 1'h0;
    logic sd_ok = 1'h0;
    logic [2:0] sd_prev;
    int len;
    int cyc = 0;
    int err_count = 0;
    int tests_run = 0;

    // Flag pins are open to the bench's pull-up driver when released
    assign f2_wire = f2_oe ? f2_o : f2_drv;
    assign f3_wire = f3_oe ? f3_o : f3_drv;
    assign sel4 = {(f3m == F3_BANK) ? f3_wire : 1'h1, (f2m == F2_BANK) ? f2_wire : 1'h1, bsel_n};

    always #25 core_clk = ~core_clk;

    external_memory_strobes #(.STROBE_LEN(SLEN)) external_memory_strobes_i (
        .core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .sdram_cmd_in(sd_in),
        .flag2_mode(f2m), .flag3_mode(f3m), .flag_gp_out(gp_out), .flag_gp_oe(gp_oe),
        .timer_expired(tmr), .flag2_pin_i(f2_wire), .flag3_pin_i(f3_wire),
        .flag2_pin_o(f2_o), .flag2_pin_oe(f2_oe), .flag3_pin_o(f3_o),
        .flag3_pin_oe(f3_oe), .flag_in_sync(fsync), .irq2_level(irq2),
        .external_port_boot(strap), .boot_mode(boot_mode), .ack(ack),
        .ext_addr(ext_addr), .bank_select_n(bsel_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
        .sdram_we_n(we_n)
    );

    ext_mem_model ext_mem_model_i (
        .core_clk(core_clk), .rst_b(rst_b), .sel_n(sel4), .wait_cycles(wait_c), .ack(ack)
    );

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic results();
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (e !== g) begin
            err_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // One word per access; the expectation is noted before the request is raised
    task automatic access(input logic wr, input logic cond, input logic boot,
                          input logic [1:0] bank);
        seen_t e;
        int eff;
        int w;
        int m;
        int n;
        n = 0;
        while (req_ready !== 1'h1 && n < 60) begin
            @(posedge core_clk);
            #2;
            n++;
        end
        eff = (boot && strap) ? 1 : bank;
        e.addr = {bank, 22'($urandom)};
        e.sel = 4'hF & ~(4'(4'h1 << eff));
        if (eff == 2 && f2m != F2_BANK) begin
            e.sel = 4'hF;
        end
        // Only a device that sees its select can stretch the access
        w = (cond && e.sel != 4'hF) ? $urandom_range(2) : 0;
        e.rd = !(cond && !wr);
        e.wr = !(cond && wr);
        // Least hold, or until a low ack can be seen, then the waits and done
        m = cond ? (((SLEN - 1 > SYNC_STAGES) ? SLEN - 1 : SYNC_STAGES) + 2 + w) : 2;
        exp_q.push_back(e);
        lmin_q.push_back(m);
        lmax_q.push_back(m);
        wait_c = 4'(w);
        req = {wr, cond, boot, e.addr};
        req_valid = 1'h1;
        @(posedge core_clk);
        #2;
        req_valid = 1'h0;
    endtask

    // Random SDRAM command levels, changed just after each edge
    always begin
        @(posedge core_clk);
        #2;
        sd_in = sdram_cmd_t'(3'($urandom));
    end

    // Note the command the design registers at this edge; also the hang limit
    always @(posedge core_clk) begin
        sd_prev <= sd_in;
        sd_ok <= rst_b;
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            results();
        end
    end

    // Access watcher: gathers what each access showed and checks it at done
    always @(negedge core_clk) begin
        if (!rst_b) begin
            busy = 1'h0;
        end else begin
            if (sd_ok) chk({ras_n, cas_n, we_n}, sd_prev);
            if (busy) begin
                len++;
                acc.sel = acc.sel & sel4;
                acc.rd = acc.rd & rd_n;
                acc.wr = acc.wr & wr_n;
                if (done === 1'h1) begin
                    acc.addr = ext_addr;
                    chk(exp_q.pop_front(), acc);
                    chk(len >= lmin_q.pop_front() && len <= lmax_q.pop_front(), 1);
                    busy = 1'h0;
                end
            end
            if (req_valid && req_ready === 1'h1) begin
                busy = 1'h1;
                len = 0;
                acc = {4'hF, 1'h1, 1'h1, 24'h0};
            end
            if (req_ready === 1'h1) chk({sel4, rd_n, wr_n}, 6'h3F);
            chk($countones(~sel4) <= 1, 1);
        end
    end

    // ----------------------------------------------------------------
    // Main sequence: strapped boot phase, then plain phase with flag roles
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(86));
        for (int p = 0; p < 2; p++) begin
            rst_b = 1'h0;
            strap = (p == 0);
            f2m = p ? F2_GPIO : F2_BANK;
            repeat (16) @(posedge core_clk);
            #2;
            rst_b = 1'h1;
            repeat (4) @(posedge core_clk);
            #2;
            chk(boot_mode, strap);
            // Back to back; every fifth access has a failed condition
            for (int i = 0; i < 16; i++) begin
                access(1'($urandom), i % 5 != 3, i % 4 == 0, 2'(i));
            end
            repeat (12) @(posedge core_clk);
            #2;
        end
        // Flag pins as general flags and as timer output
        for (int k = 0; k < 6; k++) begin
            gp_out = 2'($urandom);
            gp_oe = 2'($urandom);
            tmr = 1'($urandom);
            f3m = k[0] ? F3_TIMER : F3_GPIO;
            repeat (2) @(posedge core_clk);
            #2;
            chk({f2_o, f2_oe}, {gp_out[0], gp_oe[0]});
            chk({f3_o, f3_oe}, k[0] ? {tmr, 1'h1} : {gp_out[1], gp_oe[1]});
        end
        // Flag pin 2 as interrupt input: released and seen after the sync
        f2m = F2_IRQ;
        for (int k = 0; k < 4; k++) begin
            f2_drv = k[0];
            repeat (5) @(posedge core_clk);
            #2;
            chk({irq2, f2_oe, fsync}, {f2_drv, 1'h0, tmr, f2_drv});
        end
        results();
    end
endmodule

`default_nettype wire
